// *** src/pes_pkg.sv ***
// package for the performance event signalling block
// assumes one core clock; shared by the top and both leaf modules
`default_nettype none
package pes_pkg;
  localparam int SLOTS       = 2;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int EXPORT_W    = 58;
  localparam int NUM_CNT     = 4;
  // event numbers
  localparam logic [7:0] EV_PC_CHANGE  = 8'h0C;
  localparam logic [7:0] EV_IMM_BRANCH = 8'h0D;
  localparam logic [7:0] EV_RENAME_ALL = 8'h68;
  localparam logic [7:0] EV_VECTOR     = 8'h74;
  localparam logic [7:0] EV_ISB        = 8'h90;
  // export bus bit positions
  localparam int XB_PC_CHANGE  = 13;
  localparam int XB_IMM_BRANCH = 14;
  localparam int XB_RENAME_LO  = 8;
  localparam int XB_VECTOR_LO  = 37;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_MASK      = 8'h08;
  localparam logic [7:0] OFF_CNT_BASE  = 8'h10;
  localparam logic [7:0] OFF_CNT_STEP  = 8'h08;
  localparam logic [7:0] OFF_EVSEL_REL = 8'h00;
  localparam logic [7:0] OFF_COUNT_REL = 8'h04;
  // field positions and reset values
  localparam int CTRL_GLOBAL_EN = 0;
  localparam int EVSEL_EN_BIT   = 8;
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_MASK  = 32'h0000_0000;
  localparam logic [8:0]  RST_EVSEL = 9'h000;

  typedef enum logic [5:0] {
    IC_PLAIN     = 6'h01,
    IC_BR_IMM_NL = 6'h02,
    IC_ISB       = 6'h04,
    IC_HANDLER   = 6'h08,
    IC_EXT_STATE = 6'h10,
    IC_VECTOR    = 6'h20
  } pes_iclass_t;

  typedef struct packed {
    logic        valid;
    pes_iclass_t cls;
  } pes_slot_t;

  typedef struct packed {
    logic [1:0] rename_all;
    logic [1:0] vector;
    logic [1:0] pc_change;
    logic [1:0] imm_branch;
    logic [1:0] instruction_sync_barrier;
  } pes_evt_t;
endpackage
`default_nettype wire

// *** src/pes_classify.sv ***
// per-cycle event classification of the rename-stage slots
// assumes slot contents are held stable by the pipeline while stalled
`default_nettype none
module pes_classify (
  input  wire pes_pkg::pes_slot_t [pes_pkg::SLOTS-1:0] slots,
  input  wire logic                                    stall,
  input  wire logic                                    stall_prev,
  input  wire logic                                    sw_pc_change,
  input  wire logic                                    imm_branch,
  output pes_pkg::pes_evt_t                            evt
);
  function automatic logic hidable(input pes_pkg::pes_iclass_t c);
    hidable = (c == pes_pkg::IC_BR_IMM_NL) || (c == pes_pkg::IC_ISB) ||
              (c == pes_pkg::IC_HANDLER) || (c == pes_pkg::IC_EXT_STATE);
  endfunction

  function automatic logic [1:0] sat_add(input logic [1:0] a,
                                         input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[2] ? 2'h3 : s[1:0];
  endfunction

  always_comb begin
    logic pass;
    pass = 1'b0;
    evt  = '0;
    for (int i = 0; i < pes_pkg::SLOTS; i++) begin
      pass = slots[i].valid & ~stall;
      // slot after a stall cycle may lose hidable classes
      if (pass && !(stall_prev && hidable(slots[i].cls))) begin
        evt.rename_all = sat_add(evt.rename_all, 2'h1);
      end
      // vector count ignores stalls: n stall cycles add n
      if (slots[i].valid && slots[i].cls == pes_pkg::IC_VECTOR) begin
        evt.vector = sat_add(evt.vector, 2'h1);
      end
      if (pass && slots[i].cls == pes_pkg::IC_ISB) begin
        evt.instruction_sync_barrier = sat_add(evt.instruction_sync_barrier, 2'h1);
      end
    end
    // barrier is a branch internally
    evt.pc_change  = sat_add(evt.instruction_sync_barrier, {1'b0, sw_pc_change});
    evt.imm_branch = sat_add(evt.instruction_sync_barrier, {1'b0, imm_branch});
  end
endmodule
`default_nettype wire

// *** src/pes_counter.sv ***
// one programmable event counter with its event selector
// assumes writes come from the register port of the top
`default_nettype none
module pes_counter #(
  parameter int W = 32
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              global_en,
  input  wire pes_pkg::pes_evt_t evt,
  input  wire logic              wr_evsel,
  input  wire logic              wr_count,
  input  wire logic [W-1:0]      wdata,
  output logic [8:0]             evsel,
  output logic [W-1:0]           count,
  output logic                   ovf
);
  function automatic logic [1:0] pick(input logic [7:0] n,
                                      input pes_pkg::pes_evt_t e);
    if (n == pes_pkg::EV_PC_CHANGE) begin
      pick = e.pc_change;
    end else if (n == pes_pkg::EV_IMM_BRANCH) begin
      pick = e.imm_branch;
    end else if (n == pes_pkg::EV_RENAME_ALL) begin
      pick = e.rename_all;
    end else if (n == pes_pkg::EV_VECTOR) begin
      pick = e.vector;
    end else if (n == pes_pkg::EV_ISB) begin
      pick = e.instruction_sync_barrier;
    end else begin
      pick = 2'h0;
    end
  endfunction

  logic         active;
  logic [1:0]   inc;
  logic [W:0]   next_sum;

  assign active   = global_en & evsel[pes_pkg::EVSEL_EN_BIT];
  assign inc      = pick(evsel[7:0], evt);
  assign next_sum = {1'b0, count} + {{(W-1){1'b0}}, inc};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evsel <= pes_pkg::RST_EVSEL;
    end else if (wr_evsel) begin
      evsel <= wdata[8:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      ovf   <= 1'b0;
    end else begin
      ovf <= 1'b0;
      if (wr_count) begin
        count <= wdata;
      end else if (active) begin
        count <= next_sum[W-1:0];
        ovf   <= next_sum[W];
      end
    end
  end

  a_count_hold: assert property (@(posedge clk) disable iff (!resetn)
    (!active && !wr_count) |=> $stable(count))
    else $error("counter moved while not enabled");

  a_count_step: assert property (@(posedge clk) disable iff (!resetn)
    (active && !wr_count) |=> count == W'($past(count) + $past(inc)))
    else $error("counter did not add the selected event");
endmodule
`default_nettype wire

// *** src/pes_top.sv ***
// performance event signalling: classification, counters, export bus
// assumes rename slot inputs are synchronous to CLK_SYS and held
// stable by the pipeline during a stall; register port never waits
//
// The address map and the plain strobed port were left to the implementer.
`default_nettype none
// Functional notes
// - an executed barrier raises both pc-change and immediate branch events
// - export bit 13 is pc-change, bit 14 immediate branch, barrier included
// - separate barrier event lets software subtract barriers from branch totals
// - vector rename count ignores stalls; n held cycles add n
// - export bits 38..37 mirror the vector rename event per cycle
// - renamed instructions counted and exported on bits 9..8, except hidable ones in the cycle after a stall
// - after a stall cycle hidable branch-type instructions may be omitted
// - counting only when globally enabled and a counter selects the event
module pes_top #(
  parameter int NUM_CNT  = pes_pkg::NUM_CNT,
  parameter int EXPORT_W = pes_pkg::EXPORT_W
) (
  input  wire logic                                    CLK_SYS,
  input  wire logic                                    RESETN,
  input  wire pes_pkg::pes_slot_t [pes_pkg::SLOTS-1:0] REN_SLOT,
  input  wire logic                                    REN_STALL,
  input  wire logic                                    BR_SW_PC_CHANGE,
  input  wire logic                                    BR_IMM,
  input  wire logic [pes_pkg::ADDR_W-1:0]              REG_ADDR,
  input  wire logic [pes_pkg::DATA_W-1:0]              REG_WDATA,
  input  wire logic                                    REG_WR,
  input  wire logic                                    REG_RD,
  output logic [pes_pkg::DATA_W-1:0]                   REG_RDATA,
  output logic [EXPORT_W-1:0]                          PERF_EVENT_EXPORT_BUS,
  output logic                                         IRQ
);
  localparam int DW = pes_pkg::DATA_W;
  // export bits that carry an event; the rest must stay low
  localparam logic [EXPORT_W-1:0] XB_USED =
    (EXPORT_W'(1'h1) << pes_pkg::XB_PC_CHANGE) |
    (EXPORT_W'(1'h1) << pes_pkg::XB_IMM_BRANCH) |
    (EXPORT_W'(2'h3) << pes_pkg::XB_RENAME_LO) |
    (EXPORT_W'(2'h3) << pes_pkg::XB_VECTOR_LO);

  pes_pkg::pes_evt_t       evt;
  logic                    stall_prev;
  logic                    ctrl_global_en;
  logic [NUM_CNT-1:0]      status;
  logic [NUM_CNT-1:0]      mask;
  logic [NUM_CNT-1:0]      ovf;
  logic [NUM_CNT-1:0]      wr_evsel;
  logic [NUM_CNT-1:0]      wr_count;
  logic [8:0]              evsel [NUM_CNT];
  logic [DW-1:0]           count [NUM_CNT];
  logic [EXPORT_W-1:0]     next_export;
  logic [DW-1:0]           next_rdata;
  logic [NUM_CNT-1:0]      next_status;
  logic                    rd_status;
  logic [NUM_CNT-1:0]      next_mask;

  // counter register decode, shared by write and read paths
  function automatic logic cnt_hit(input logic [7:0] a, input int i,
                                   input logic [7:0] rel);
    logic [7:0] base;
    base = pes_pkg::OFF_CNT_BASE + 8'(i) * pes_pkg::OFF_CNT_STEP;
    cnt_hit = (a == base + rel);
  endfunction

  pes_classify u_classify (
    .slots        (REN_SLOT),
    .stall        (REN_STALL),
    .stall_prev   (stall_prev),
    .sw_pc_change (BR_SW_PC_CHANGE),
    .imm_branch   (BR_IMM),
    .evt          (evt)
  );

  // stall of the previous cycle decides hiding in this one
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      stall_prev <= 1'b0;
    end else begin
      stall_prev <= REN_STALL;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      assign wr_evsel[g] = REG_WR &
        cnt_hit(REG_ADDR, g, pes_pkg::OFF_EVSEL_REL);
      assign wr_count[g] = REG_WR &
        cnt_hit(REG_ADDR, g, pes_pkg::OFF_COUNT_REL);

      pes_counter #(
        .W (DW)
      ) u_cnt (
        .clk       (CLK_SYS),
        .resetn    (RESETN),
        .global_en (ctrl_global_en),
        .evt       (evt),
        .wr_evsel  (wr_evsel[g]),
        .wr_count  (wr_count[g]),
        .wdata     (REG_WDATA),
        .evsel     (evsel[g]),
        .count     (count[g]),
        .ovf       (ovf[g])
      );
    end
  endgenerate

  // export bus: one registered sample of this cycle's events
  always_comb begin
    next_export = '0;
    next_export[pes_pkg::XB_PC_CHANGE]  = |evt.pc_change;
    next_export[pes_pkg::XB_IMM_BRANCH] = |evt.imm_branch;
    // binary occurrence count per cycle
    next_export[pes_pkg::XB_RENAME_LO +: 2] = evt.rename_all;
    next_export[pes_pkg::XB_VECTOR_LO +: 2] = evt.vector;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PERF_EVENT_EXPORT_BUS <= '0;
    end else begin
      PERF_EVENT_EXPORT_BUS <= next_export;
    end
  end

  // control register: global enable
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_global_en <= pes_pkg::RST_CTRL[pes_pkg::CTRL_GLOBAL_EN];
    end else if (REG_WR && REG_ADDR == pes_pkg::OFF_CTRL) begin
      ctrl_global_en <= REG_WDATA[pes_pkg::CTRL_GLOBAL_EN];
    end
  end

  // irq reads next_mask, so it never lags a mask write by a cycle
  always_comb begin
    next_mask = mask;
    if (REG_WR && REG_ADDR == pes_pkg::OFF_MASK) begin
      next_mask = REG_WDATA[NUM_CNT-1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mask <= pes_pkg::RST_MASK[NUM_CNT-1:0];
    end else begin
      mask <= next_mask;
    end
  end

  // sticky overflow flags; a new overflow beats the read-clear
  assign rd_status = REG_RD && REG_ADDR == pes_pkg::OFF_STATUS;

  always_comb begin
    next_status = rd_status ? ovf : (status | ovf);
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // level irq, registered alongside status and mask
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_status & next_mask);
    end
  end

  // read data valid in the cycle after the strobe only
  always_comb begin
    next_rdata = '0;
    if (REG_ADDR == pes_pkg::OFF_CTRL) begin
      next_rdata[pes_pkg::CTRL_GLOBAL_EN] = ctrl_global_en;
    end else if (REG_ADDR == pes_pkg::OFF_STATUS) begin
      next_rdata[NUM_CNT-1:0] = status;
    end else if (REG_ADDR == pes_pkg::OFF_MASK) begin
      next_rdata[NUM_CNT-1:0] = mask;
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (cnt_hit(REG_ADDR, i, pes_pkg::OFF_EVSEL_REL)) begin
          next_rdata[8:0] = evsel[i];
        end else if (cnt_hit(REG_ADDR, i, pes_pkg::OFF_COUNT_REL)) begin
          next_rdata = count[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= '0;
    end
  end

  // checks
  sequence s_isb_passes;
    !REN_STALL && REN_SLOT[0].valid &&
    REN_SLOT[0].cls == pes_pkg::IC_ISB;
  endsequence

  sequence s_both_branch_bits;
    PERF_EVENT_EXPORT_BUS[pes_pkg::XB_PC_CHANGE] &&
    PERF_EVENT_EXPORT_BUS[pes_pkg::XB_IMM_BRANCH];
  endsequence

  a_isb_as_branch: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    s_isb_passes |=> s_both_branch_bits)
    else $error("barrier did not raise both branch export bits");

  a_branch_bits_cause: assert property (@(posedge CLK_SYS)
    disable iff (!RESETN)
    PERF_EVENT_EXPORT_BUS[pes_pkg::XB_PC_CHANGE] |->
      $past(BR_SW_PC_CHANGE) || $past(evt.instruction_sync_barrier) != 2'h0)
    else $error("pc change bit without a cause");

  a_vector_stall: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (REN_STALL && REN_SLOT[0].valid &&
     REN_SLOT[0].cls == pes_pkg::IC_VECTOR)[*2] |=>
      PERF_EVENT_EXPORT_BUS[pes_pkg::XB_VECTOR_LO +: 2] != 2'h0)
    else $error("held vector instruction not counted while stalled");

  a_rename_export: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    ##1 PERF_EVENT_EXPORT_BUS[pes_pkg::XB_RENAME_LO +: 2] ==
      $past(evt.rename_all))
    else $error("rename export field differs from the event count");

  a_stall_hides: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (stall_prev && !REN_STALL && !REN_SLOT[1].valid &&
     REN_SLOT[0].cls == pes_pkg::IC_BR_IMM_NL) |=>
      PERF_EVENT_EXPORT_BUS[pes_pkg::XB_RENAME_LO +: 2] == 2'h0)
    else $error("hidable branch after stall was counted");

  a_stall_no_rename: assert property (@(posedge CLK_SYS)
    disable iff (!RESETN)
    REN_STALL |=> PERF_EVENT_EXPORT_BUS[pes_pkg::XB_RENAME_LO +: 2] == 2'h0)
    else $error("rename count during a stall cycle");

  a_status_read_clr: assert property (@(posedge CLK_SYS)
    disable iff (!RESETN)
    (rd_status && ovf == '0) |=> status == '0)
    else $error("status not cleared by its read");

  a_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    ##1 IRQ == |(status & mask))
    else $error("irq does not follow masked status");

  sequence s_single_slot;
    !stall_prev && !REN_STALL && REN_SLOT[0].valid &&
    !REN_SLOT[1].valid;
  endsequence

  sequence s_vector_held;
    REN_STALL && REN_SLOT[1].valid &&
    REN_SLOT[1].cls == pes_pkg::IC_VECTOR;
  endsequence

  a_export_unused: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    (PERF_EVENT_EXPORT_BUS & ~XB_USED) == '0)
    else $error("export bit outside the event fields set");

  a_pc_bit_direct: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    BR_SW_PC_CHANGE |=> PERF_EVENT_EXPORT_BUS[pes_pkg::XB_PC_CHANGE])
    else $error("pc change input not exported");

  a_imm_bit_direct: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    BR_IMM |=> PERF_EVENT_EXPORT_BUS[pes_pkg::XB_IMM_BRANCH])
    else $error("immediate branch input not exported");

  a_imm_bit_cause: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    PERF_EVENT_EXPORT_BUS[pes_pkg::XB_IMM_BRANCH] |->
      $past(BR_IMM) || $past(evt.instruction_sync_barrier) != 2'h0)
    else $error("immediate branch bit without a cause");

  a_vector_export: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    ##1 PERF_EVENT_EXPORT_BUS[pes_pkg::XB_VECTOR_LO +: 2] ==
      $past(evt.vector))
    else $error("vector export field differs from the event");

  a_vector_slot1: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    s_vector_held |=>
      PERF_EVENT_EXPORT_BUS[pes_pkg::XB_VECTOR_LO +: 2] != 2'h0)
    else $error("stalled vector in slot 1 not counted");

  a_rename_single: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    s_single_slot |=>
      PERF_EVENT_EXPORT_BUS[pes_pkg::XB_RENAME_LO +: 2] == 2'h1)
    else $error("single renamed slot not exported as one");

  a_isb_counted: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    s_isb_passes |-> evt.instruction_sync_barrier != 2'h0)
    else $error("advancing barrier not counted");

  a_stall_no_isb: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    REN_STALL |-> evt.instruction_sync_barrier == 2'h0)
    else $error("barrier counted while stalled");

  a_ctrl_write: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    (REG_WR && REG_ADDR == pes_pkg::OFF_CTRL) |=>
      ctrl_global_en == $past(REG_WDATA[pes_pkg::CTRL_GLOBAL_EN]))
    else $error("global enable missed its write");

  a_evsel_write: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    wr_evsel[0] |=> evsel[0] == $past(REG_WDATA[8:0]))
    else $error("event selector missed its write");

  a_status_set: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (ovf != '0) |=> (status & $past(ovf)) == $past(ovf))
    else $error("overflow lost from status");

  a_status_sticky: assert property (@(posedge CLK_SYS)
    disable iff (!RESETN)
    !rd_status |=> (status & $past(status)) == $past(status))
    else $error("status bit cleared without a read");

  a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !REG_RD |=> REG_RDATA == '0)
    else $error("read data shown without a read");
endmodule
`default_nettype wire

// *** verification/pes_ext_tally.sv ***
// external tally of the event export bus, a far-side counter model
// assumes the bus is registered on the core clock rising edge
`default_nettype none
module pes_ext_tally (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic [pes_pkg::EXPORT_W-1:0] bus,
  output logic      [31:0]                  rename_sum,
  output logic      [31:0]                  vector_sum
);
  timeunit 1ns;
  timeprecision 1ns;
  // counts the fields straight off the wire, no enable of its own
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rename_sum <= '0;
      vector_sum <= '0;
    end else begin
      rename_sum <= rename_sum + 32'(bus[9:8]);
      vector_sum <= vector_sum + 32'(bus[38:37]);
    end
  end
endmodule
`default_nettype wire

// *** verification/perf_event_signalling_tb.sv ***
// self-checking bench for the performance event signalling top
// assumes pes_pkg is compiled first; one 100 MHz core clock
`default_nettype none
module perf_event_signalling_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                    CLK_SYS = 1'b0;
  logic                                    RESETN;
  pes_pkg::pes_slot_t [pes_pkg::SLOTS-1:0] REN_SLOT;
  logic                                    REN_STALL;
  logic                                    BR_SW_PC_CHANGE;
  logic                                    BR_IMM;
  logic                                    REG_WR;
  logic                                    REG_RD;
  logic                                    IRQ;
  logic [7:0]                              REG_ADDR;
  logic [31:0]                             REG_WDATA;
  logic [31:0]                             REG_RDATA;
  logic [57:0]                             bus;
  logic [57:0]                             exp_bus;
  logic [31:0]                             ext_ren;
  logic [31:0]                             ext_vec;
  logic                                    stall_q;
  logic [31:0]                             sum [4];
  pes_pkg::pes_evt_t                       ev;
  int                                      err_count = 0;
  int                                      samples_checked = 0;
  pes_pkg::pes_iclass_t cls_tab [6] = '{pes_pkg::IC_PLAIN,
    pes_pkg::IC_BR_IMM_NL, pes_pkg::IC_ISB, pes_pkg::IC_HANDLER,
    pes_pkg::IC_EXT_STATE, pes_pkg::IC_VECTOR};
  logic [7:0] evn [4] = '{pes_pkg::EV_PC_CHANGE, pes_pkg::EV_RENAME_ALL,
    pes_pkg::EV_VECTOR, pes_pkg::EV_ISB};

  always #5 CLK_SYS = ~CLK_SYS;

  pes_top #(.NUM_CNT(4), .EXPORT_W(58)) DUT (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .REN_SLOT(REN_SLOT),
    .REN_STALL(REN_STALL), .BR_SW_PC_CHANGE(BR_SW_PC_CHANGE),
    .BR_IMM(BR_IMM), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PERF_EVENT_EXPORT_BUS(bus), .IRQ(IRQ));

  pes_ext_tally ext (.clk(CLK_SYS), .resetn(RESETN), .bus(bus),
    .rename_sum(ext_ren), .vector_sum(ext_vec));

  function automatic pes_pkg::pes_evt_t calc(
    input pes_pkg::pes_slot_t [1:0] s, input logic st, input logic stp,
    input logic sw, input logic im);
    pes_pkg::pes_evt_t e;
    logic              hid;
    e = '0;
    for (int i = 0; i < 2; i++) begin
      hid = s[i].cls inside {pes_pkg::IC_BR_IMM_NL, pes_pkg::IC_ISB,
        pes_pkg::IC_HANDLER, pes_pkg::IC_EXT_STATE};
      if (s[i].valid && s[i].cls == pes_pkg::IC_VECTOR) begin
        e.vector = e.vector + 2'h1;
      end
      if (s[i].valid && !st && !(stp && hid)) begin
        e.rename_all = e.rename_all + 2'h1;
      end
      if (s[i].valid && !st && s[i].cls == pes_pkg::IC_ISB) begin
        e.instruction_sync_barrier = e.instruction_sync_barrier + 2'h1;
      end
    end
    e.pc_change = e.instruction_sync_barrier + {1'b0, sw};
    e.imm_branch = e.instruction_sync_barrier + {1'b0, im};
    return e;
  endfunction

  function automatic logic [57:0] to_bus(input pes_pkg::pes_evt_t e);
    logic [57:0] b;
    b = '0;
    b[9:8] = e.rename_all;
    b[38:37] = e.vector;
    b[13] = |e.pc_change;
    b[14] = |e.imm_branch;
    return b;
  endfunction

  assign ev = calc(REN_SLOT, REN_STALL, stall_q, BR_SW_PC_CHANGE, BR_IMM);

  // reference sums: 0 pc change, 1 renamed, 2 vector, 3 barrier
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      stall_q <= 1'b0;
      exp_bus <= '0;
      sum <= '{default: 32'h0};
    end else begin
      stall_q <= REN_STALL;
      exp_bus <= to_bus(ev);
      sum[0] <= sum[0] + 32'(ev.pc_change);
      sum[1] <= sum[1] + 32'(ev.rename_all);
      sum[2] <= sum[2] + 32'(ev.vector);
      sum[3] <= sum[3] + 32'(ev.instruction_sync_barrier);
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] expv);
    samples_checked++;
    if (got !== expv) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask

  // export bus compared every cycle, settled at the falling edge
  always @(negedge CLK_SYS) begin
    if (RESETN === 1'b1) begin
      chk(64'(bus), 64'(exp_bus));
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_SYS);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    @(negedge CLK_SYS);
    d = REG_RDATA;
  endtask

  task automatic burst(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge CLK_SYS);
      REN_STALL <= ($urandom % 3) == 0;
      BR_SW_PC_CHANGE <= ($urandom % 5) == 0;
      BR_IMM <= ($urandom % 5) == 0;
      // a stalled slot must stay put, as the pipeline holds it
      if (!REN_STALL) begin
        for (int i = 0; i < 2; i++) begin
          REN_SLOT[i].valid <= ($urandom % 4) != 0;
          REN_SLOT[i].cls <= cls_tab[$urandom % 6];
        end
      end
    end
  endtask

  task automatic idle(input int n);
    @(posedge CLK_SYS);
    REN_SLOT <= '0;
    REN_STALL <= 1'b0;
    BR_SW_PC_CHANGE <= 1'b0;
    BR_IMM <= 1'b0;
    repeat (n) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK_SYS);
    err_count++;
    end_sim;
  end

  initial begin
    logic [31:0] d;
    logic [31:0] save [4];
    RESETN = 1'b0;
    REN_SLOT = '0;
    REN_STALL = 1'b0;
    BR_SW_PC_CHANGE = 1'b0;
    BR_IMM = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 32'h0;
    void'($urandom(77));
    repeat (20) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h10 + 8'(8 * i), {23'h0, 1'b1, evn[i]});
    end
    wr(pes_pkg::OFF_CTRL, 32'h1);
    burst(1500);
    idle(4);
    wr(pes_pkg::OFF_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(8'h14 + 8'(8 * i), d);
      chk(64'(d), 64'(sum[i]));
      save[i] = sum[i];
    end
    // counting off: traffic must leave every counter alone
    burst(300);
    idle(4);
    for (int i = 0; i < 4; i++) begin
      rd(8'h14 + 8'(8 * i), d);
      chk(64'(d), 64'(save[i]));
    end
    chk(64'(ext_ren), 64'(sum[1]));
    chk(64'(ext_vec), 64'(sum[2]));
    // barrier and vector held three stalled cycles, then released
    @(posedge CLK_SYS);
    REN_SLOT[0] <= '{1'b1, pes_pkg::IC_ISB};
    REN_SLOT[1] <= '{1'b1, pes_pkg::IC_VECTOR};
    REN_STALL <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    REN_STALL <= 1'b0;
    idle(3);
    // overflow raises status; masked first, then unmasked
    wr(pes_pkg::OFF_MASK, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    wr(8'h18, {23'h0, 1'b1, pes_pkg::EV_IMM_BRANCH});
    wr(8'h1C, 32'h0);
    wr(pes_pkg::OFF_CTRL, 32'h1);
    @(posedge CLK_SYS);
    REN_SLOT[0] <= '{1'b1, pes_pkg::IC_ISB};
    idle(4);
    chk(64'(IRQ), 64'h0);
    wr(pes_pkg::OFF_MASK, 32'h1);
    idle(2);
    chk(64'(IRQ), 64'h1);
    rd(pes_pkg::OFF_STATUS, d);
    chk(64'(d), 64'h1);
    rd(8'h14, d);
    chk(64'(d), 64'h0);
    rd(8'h1C, d);
    chk(64'(d), 64'h1);
    idle(3);
    chk(64'(IRQ), 64'h0);
    rd(8'hFC, d);
    chk(64'(d), 64'h0);
    end_sim;
  end
endmodule
`default_nettype wire
